// ===== omh_clear_timer.sv
// Counts the cycles a clear action is held before the new mode is entered.
// Runs on the top module's clock, synchronised reset and clock enable.
`timescale 1ns/100ps
`include "omh_defs.svh"
module omh_clear_timer
  import omh_pkg::*;
#(
  parameter int CYCLES = `OMH_CLEAR_DONE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  output logic done
);
  logic [7:0] cnt_r;
  // Load on start, count down to zero; done at one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else if (ce) begin
      if (start) begin
        cnt_r <= 8'(CYCLES);
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
  assign done = (cnt_r == 8'h01);
endmodule

// ===== omh_defs.svh
// Constants for the operating-mode hold controller.
// Included by the package and design modules; definitions only.
`ifndef OMH_DEFS_SVH
`define OMH_DEFS_SVH
`define OMH_ADDR_W 8
`define OMH_DATA_W 16
`define OMH_OFF_HOLD_CFG 8'h50
`define OMH_OFF_MODE_CFG 8'h51
`define OMH_OFF_CTRL 8'h52
`define OMH_OFF_STATUS 8'h53
`define OMH_HOLD_CFG_BIT 15
`define OMH_CTRL_HOLD_BIT 0
`define OMH_CTRL_REQ_LSB 1
`define OMH_CTRL_REQ_VALID 3
`define OMH_HOLD_CFG_RST 16'h0000
`define OMH_MODE_CFG_RST 16'h0000
`define OMH_CLEAR_DONE_CYC 3
`endif

// ===== omh_pkg.sv
// Types for the operating-mode hold controller.
// Assumes omh_defs.svh is on the include path.
`include "omh_defs.svh"
package omh_pkg;
  // Operating modes
  typedef enum logic [1:0] {
    OMH_PROGRAM = 2'b00,
    OMH_MONITOR = 2'b01,
    OMH_RUN = 2'b10
  } omh_mode_t;
  // Startup mode selections
  typedef enum logic [1:0] {
    OMH_SEL_CONSOLE = 2'b00,
    OMH_SEL_PROGRAM = 2'b01,
    OMH_SEL_MONITOR = 2'b10,
    OMH_SEL_RUN = 2'b11
  } omh_sel_t;
  // Sequencer states
  typedef enum logic [1:0] {
    OMH_ST_BOOT = 2'b00,
    OMH_ST_IDLE = 2'b01,
    OMH_ST_CLEAR = 2'b10,
    OMH_ST_FREEZE = 2'b11
  } omh_state_t;
  // Clear strobes to memory and output subsystems
  typedef struct packed {
    logic core_io;
    logic work;
    logic timer_flags;
    logic timer_pv;
    logic outputs;
  } omh_clear_t;
endpackage

// ===== omh_top.sv
// Operating-mode hold controller: mode changes, hold flag, startup mode, run output.
// Assumes a single 125 MHz clock and memory/output units that obey clear and freeze strobes.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "omh_defs.svh"
module omh_top
  import omh_pkg::*;
#(
  parameter int CLEAR_CYCLES = `OMH_CLEAR_DONE_CYC
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic [`OMH_ADDR_W-1:0] ADDR,
  input wire logic [`OMH_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [`OMH_DATA_W-1:0] RDATA,
  input wire logic CONSOLE_PRESENT,
  input wire logic [1:0] CONSOLE_SWITCH,
  input wire logic HOLD_FLAG_SAVED,
  input wire logic CONFIG_VALID,
  output logic [1:0] MODE,
  output logic EXECUTE,
  output logic RUN_STATUS,
  output logic OUTPUT_FREEZE,
  output omh_clear_t CLEAR,
  output logic MEMORY_HOLD_FLAG
);
  logic rst_s1_r;
  logic rst_n_r;
  omh_state_t state_r;
  omh_mode_t mode_r;
  omh_mode_t target_r;
  logic hold_r;
  logic latched_hold_r;
  logic [`OMH_DATA_W-1:0] hold_cfg_r;
  logic [`OMH_DATA_W-1:0] mode_cfg_r;
  logic [2:0] req_r;
  logic [`OMH_DATA_W-1:0] rdata_nxt;
  logic clr_start;
  logic clr_done;
  logic req_pending;
  logic boot_done_r;

  // Decode the startup mode selection
  function automatic omh_mode_t start_mode(input logic [1:0] sel, input logic console,
                                           input logic [1:0] sw);
    case (omh_sel_t'(sel))
      OMH_SEL_PROGRAM: start_mode = OMH_PROGRAM;
      OMH_SEL_MONITOR: start_mode = OMH_MONITOR;
      OMH_SEL_RUN: start_mode = OMH_RUN;
      default: start_mode = console ? to_mode(sw) : OMH_RUN;
    endcase
  endfunction

  // Map a two-bit mode code, unknown codes treated as program
  function automatic omh_mode_t to_mode(input logic [1:0] code);
    case (code)
      2'b01: to_mode = OMH_MONITOR;
      2'b10: to_mode = OMH_RUN;
      default: to_mode = OMH_PROGRAM;
    endcase
  endfunction

  // True when crossing the program / run-monitor boundary
  function automatic logic crosses(input omh_mode_t a, input omh_mode_t b);
    crosses = (a == OMH_PROGRAM) != (b == OMH_PROGRAM);
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Configuration registers and software mode request
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hold_cfg_r <= `OMH_HOLD_CFG_RST;
      mode_cfg_r <= `OMH_MODE_CFG_RST;
      req_r <= 3'h0;
    end else if (CE) begin
      if (WR && ADDR == `OMH_OFF_HOLD_CFG) begin
        hold_cfg_r <= WDATA;
      end else if (WR && ADDR == `OMH_OFF_MODE_CFG) begin
        mode_cfg_r <= WDATA;
      end else if (WR && ADDR == `OMH_OFF_CTRL) begin
        req_r <= WDATA[`OMH_CTRL_REQ_VALID:`OMH_CTRL_REQ_LSB];
      end else if (state_r == OMH_ST_IDLE) begin
        req_r[2] <= 1'b0; // Request consumed
      end
    end
  end

  // Memory hold flag: power-on load, then software writes
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hold_r <= 1'b0;
    end else if (CE) begin
      if (state_r == OMH_ST_BOOT) begin
        hold_r <= HOLD_FLAG_SAVED & hold_cfg_r[`OMH_HOLD_CFG_BIT];
      end else if (WR && ADDR == `OMH_OFF_CTRL) begin
        hold_r <= WDATA[`OMH_CTRL_HOLD_BIT];
      end
    end
  end

  // Pending mode request; a clear starts on a program/run crossing with the hold flag off
  assign req_pending = req_r[2] && (to_mode(req_r[1:0]) != mode_r);
  assign clr_start = (state_r == OMH_ST_IDLE) && req_pending && crosses(mode_r, to_mode(req_r[1:0]))
                     && !hold_r;

  // Mode sequencer
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= OMH_ST_BOOT;
      mode_r <= OMH_PROGRAM;
      target_r <= OMH_PROGRAM;
      latched_hold_r <= 1'b0;
      boot_done_r <= 1'b0;
    end else if (CE) begin
      case (state_r)
        OMH_ST_BOOT: begin
          if (CONFIG_VALID) begin
            target_r <= start_mode(mode_cfg_r[1:0], CONSOLE_PRESENT, CONSOLE_SWITCH);
            latched_hold_r <= HOLD_FLAG_SAVED & hold_cfg_r[`OMH_HOLD_CFG_BIT];
            state_r <= OMH_ST_CLEAR;
            boot_done_r <= 1'b1;
          end
        end
        OMH_ST_IDLE: begin
          if (req_pending) begin
            target_r <= to_mode(req_r[1:0]);
            latched_hold_r <= hold_r;
            if (crosses(mode_r, to_mode(req_r[1:0]))) begin
              state_r <= hold_r ? OMH_ST_FREEZE : OMH_ST_CLEAR;
            end else begin
              mode_r <= to_mode(req_r[1:0]);
            end
          end
        end
        OMH_ST_CLEAR: begin
          if (latched_hold_r || clr_done) begin
            mode_r <= target_r;
            state_r <= OMH_ST_IDLE;
          end
        end
        default: begin
          mode_r <= target_r;
          state_r <= OMH_ST_IDLE;
        end
      endcase
    end
  end

  // Clear hold-off timer, started on entry to the clear state without hold
  omh_clear_timer #(
    .CYCLES(CLEAR_CYCLES)
  ) u_clr (
    .clk(CLOCK),
    .rst_n(rst_n_r),
    .ce(CE),
    .start(clr_start || (state_r == OMH_ST_BOOT && CONFIG_VALID && !(HOLD_FLAG_SAVED &
           hold_cfg_r[`OMH_HOLD_CFG_BIT]))),
    .done(clr_done)
  );

  // Clear strobes while clearing without hold
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      CLEAR <= '0;
    end else if (CE) begin
      CLEAR.core_io <= clr_start || (state_r == OMH_ST_CLEAR && !latched_hold_r && !clr_done);
      CLEAR.work <= clr_start || (state_r == OMH_ST_CLEAR && !latched_hold_r && !clr_done);
      CLEAR.timer_flags <= clr_start || (state_r == OMH_ST_CLEAR && !latched_hold_r && !clr_done);
      CLEAR.timer_pv <= clr_start || (state_r == OMH_ST_CLEAR && !latched_hold_r && !clr_done);
      CLEAR.outputs <= clr_start || (state_r == OMH_ST_CLEAR && !latched_hold_r && !clr_done);
    end
  end

  // Outputs frozen with hold set in program mode or outside the idle state
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      OUTPUT_FREEZE <= 1'b0;
    end else if (CE) begin
      OUTPUT_FREEZE <= hold_r && (mode_r == OMH_PROGRAM || state_r != OMH_ST_IDLE);
    end
  end

  // Read mux, one cycle latency; unmapped reads zero
  always_comb begin
    rdata_nxt = '0;
    if (ADDR == `OMH_OFF_HOLD_CFG) begin
      rdata_nxt = hold_cfg_r;
    end else if (ADDR == `OMH_OFF_MODE_CFG) begin
      rdata_nxt = mode_cfg_r;
    end else if (ADDR == `OMH_OFF_CTRL) begin
      rdata_nxt = {12'h000, req_r, hold_r};
    end else if (ADDR == `OMH_OFF_STATUS) begin
      rdata_nxt = {11'h000, boot_done_r, state_r, mode_r};
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= RD ? rdata_nxt : '0;
    end
  end

  // Mode and run status follow the committed mode; execution stops as soon as a crossing is accepted
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      RUN_STATUS <= 1'b0;
      EXECUTE <= 1'b0;
    end else if (CE) begin
      RUN_STATUS <= (mode_r != OMH_PROGRAM);
      EXECUTE <= (mode_r != OMH_PROGRAM) && (state_r == OMH_ST_IDLE)
                 && !(req_pending && crosses(mode_r, to_mode(req_r[1:0])));
    end
  end

  assign MODE = mode_r;
  assign MEMORY_HOLD_FLAG = hold_r;
endmodule

// ===== omh_top_asserts.sv
// Checker for the operating-mode hold controller.
// Bound to omh_top; sees only the top module's ports.
`timescale 1ns/100ps
module omh_top_asserts
  import omh_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [1:0] MODE,
  input wire logic EXECUTE,
  input wire logic RUN_STATUS,
  input wire logic OUTPUT_FREEZE,
  input wire omh_clear_t CLEAR,
  input wire logic MEMORY_HOLD_FLAG
);
  // One clock domain, disabled in reset
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  // Run output follows mode one cycle later
  property p_run_out;
    RUN_STATUS == ($past(MODE) != 2'b00);
  endproperty
  a_run_out: assert property (p_run_out) else $error("run output wrong for mode");
  // Only the three mode codes appear
  property p_mode_code;
    MODE != 2'b11;
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("illegal mode code");
  // Memory areas are cleared together
  property p_clr_group;
    (CLEAR.core_io || CLEAR.work || CLEAR.timer_flags || CLEAR.timer_pv)
      |-> (CLEAR.core_io && CLEAR.work && CLEAR.timer_flags && CLEAR.timer_pv);
  endproperty
  a_clr_group: assert property (p_clr_group) else $error("partial memory clear");
  // Nothing executes while a clear is in progress
  property p_clr_noexec;
    (CLEAR != 5'h00) |-> !EXECUTE;
  endproperty
  a_clr_noexec: assert property (p_clr_noexec) else $error("execute during clear");
  // Program mode never executes
  property p_exec_mode;
    EXECUTE |-> (MODE != 2'b00);
  endproperty
  a_exec_mode: assert property (p_exec_mode) else $error("execute in program mode");
  // Frozen outputs are never cleared
  property p_freeze_noclr;
    OUTPUT_FREEZE |-> (CLEAR == 5'h00);
  endproperty
  a_freeze_noclr: assert property (p_freeze_noclr) else $error("clear while frozen");
  // A clear starts only with the hold flag off
  property p_clr_hold;
    $rose(CLEAR.work) |-> !$past(MEMORY_HOLD_FLAG);
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("clear with hold flag set");
  // Stopping with hold set clears nothing
  property p_stop_hold;
    ($fell(EXECUTE) && MEMORY_HOLD_FLAG) |-> (CLEAR == 5'h00) [*4];
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("clear on held stop");
endmodule

bind omh_top omh_top_asserts i_omh_top_asserts (.CLOCK(CLOCK), .RESET_N(RESET_N), .MODE(MODE),
  .EXECUTE(EXECUTE), .RUN_STATUS(RUN_STATUS), .OUTPUT_FREEZE(OUTPUT_FREEZE), .CLEAR(CLEAR),
  .MEMORY_HOLD_FLAG(MEMORY_HOLD_FLAG));

// ===== omh_top_tb.sv
// Self-checking bench for the operating-mode hold controller.
// Drives omh_top ports directly; the checker is bound separately.
`timescale 1ns/100ps
`include "omh_defs.svh"
module omh_top_tb
  import omh_pkg::*;
;
  logic CLOCK = 1'b0, RESET_N = 1'b0, CE = 1'b1, WR = 1'b0, RD = 1'b0;
  logic CONSOLE_PRESENT = 1'b0, HOLD_FLAG_SAVED = 1'b0, CONFIG_VALID = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic [1:0] CONSOLE_SWITCH = 2'b00;
  logic [15:0] RDATA;
  logic [1:0] MODE;
  logic EXECUTE, RUN_STATUS, OUTPUT_FREEZE, MEMORY_HOLD_FLAG;
  omh_clear_t CLEAR;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  logic saw_clr = 1'b0, saw_frz = 1'b0;
  omh_top #(.CLEAR_CYCLES(3)) i_omh_top (.CLOCK(CLOCK), .RESET_N(RESET_N), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CONSOLE_PRESENT(CONSOLE_PRESENT),
    .CONSOLE_SWITCH(CONSOLE_SWITCH), .HOLD_FLAG_SAVED(HOLD_FLAG_SAVED), .CONFIG_VALID(CONFIG_VALID),
    .MODE(MODE), .EXECUTE(EXECUTE), .RUN_STATUS(RUN_STATUS), .OUTPUT_FREEZE(OUTPUT_FREEZE),
    .CLEAR(CLEAR), .MEMORY_HOLD_FLAG(MEMORY_HOLD_FLAG));
  // Clock, 8 ns period
  initial forever #4 CLOCK = ~CLOCK;
  // Timeout and clear/freeze watchers
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (CLEAR != 5'h00) saw_clr <= 1'b1;
    if (OUTPUT_FREEZE === 1'b1) saw_frz <= 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task conclude;
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(negedge CLOCK);
    v = RDATA;
  endtask
  // Poll status until booted and idle
  task settle;
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 40 && v[4:2] !== 3'b101; i++) rd(8'h53, v);
    chk(16'(v[4:2]), 16'h0005);
  endtask
  // Power-on with given setup and inputs
  task boot(input logic [15:0] hc, input logic [1:0] sel, input logic sv, input logic pr, input logic [1:0] sw,
    input logic [1:0] em, input logic ef, input logic ec);
    logic [15:0] v;
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    CONFIG_VALID <= 1'b0;
    HOLD_FLAG_SAVED <= sv;
    CONSOLE_PRESENT <= pr;
    CONSOLE_SWITCH <= sw;
    repeat (5) @(posedge CLOCK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    rd(8'h50, v);
    chk(v, `OMH_HOLD_CFG_RST);
    wr(8'h50, hc);
    wr(8'h51, {14'h0000, sel});
    wr(8'h60, 16'hffff);
    rd(8'h60, v);
    chk(v, 16'h0000);
    rd(8'h50, v);
    chk(v, hc);
    @(posedge CLOCK);
    saw_clr <= 1'b0;
    CONFIG_VALID <= 1'b1;
    settle();
    chk({14'h0000, MODE}, {14'h0000, em});
    chk({15'h0000, MEMORY_HOLD_FLAG}, {15'h0000, ef});
    chk({15'h0000, saw_clr}, {15'h0000, ec});
  endtask
  // Mode request with hold flag value
  task chg(input logic h, input logic [1:0] m, input logic ec, input logic ef);
    wr(8'h52, {12'h000, 1'b1, m, h});
    // Forget what the old regime showed; the request acts from the next edge
    @(posedge CLOCK);
    @(negedge CLOCK);
    saw_clr <= 1'b0;
    saw_frz <= 1'b0;
    repeat (3) @(posedge CLOCK);
    settle();
    chk({14'h0000, MODE}, {14'h0000, m});
    chk({14'h0000, RUN_STATUS, EXECUTE}, {14'h0000, {2{m != 2'b00}}});
    chk({14'h0000, saw_clr, saw_frz}, {14'h0000, ec, ef});
  endtask
  initial begin
    boot(16'h0000, 2'd2, 1'b1, 1'b1, 2'b00, 2'b01, 1'b0, 1'b1);
    boot(16'h0000, 2'd3, 1'b1, 1'b1, 2'b00, 2'b10, 1'b0, 1'b1);
    boot(16'h8000, 2'd0, 1'b0, 1'b1, 2'b01, 2'b01, 1'b0, 1'b1);
    boot(16'h0000, 2'd0, 1'b1, 1'b0, 2'b00, 2'b10, 1'b0, 1'b1);
    boot(16'h8000, 2'd1, 1'b1, 1'b1, 2'b10, 2'b00, 1'b1, 1'b0);
    chg(1'b1, 2'b10, 1'b0, 1'b1);
    chg(1'b1, 2'b00, 1'b0, 1'b1);
    chg(1'b0, 2'b01, 1'b1, 1'b0);
    chg(1'b0, 2'b10, 1'b0, 1'b0);
    chg(1'b0, 2'b00, 1'b1, 1'b0);
    chg(1'b0, 2'b00, 1'b0, 1'b0);
    conclude();
  end
endmodule
